// ==== hw/io_ports.sv ====
// Function
// - a port read returns the live pin levels, except the third port on small variants, which returns its latch.
// - every reset makes all pins inputs by setting every direction bit.
// - the first port has four pins and its upper four bits read zero.
// - the second port is a full eight-bit pin register.
// - the third port has pins on large variants, else is plain storage.
// - direction bits load from the work value only on the load command.
// - direction 1 floats the driver, 0 drives the latch onto the pin.
// - a driven pin held the other way by outside reads the outside level.
// - a latch holds its value until the port is written again.
// - reads sample the pins at the read, with no input holding.
// - each pin is set as input or output on its own.
module io_ports
  import io_ports_pkg::*;
#(
  parameter bit HAS_THIRD_PINS = 1'b1 // large variant with third pins
)(
  input wire logic clk_sys, // core clock, 200 MHz
  input wire logic resetn, // power-on, clear or watchdog reset
  input wire logic clk_en, // freezes all state while low
  input wire logic file_wr, // core writes a file register
  input wire logic file_rd, // core reads a file register
  input wire logic [ADDR_W-1:0] file_addr, // file register address
  input wire logic [PORT_W-1:0] file_wdata, // write data
  input wire logic dir_load, // direction load command executes
  input wire logic [ADDR_W-1:0] dir_addr, // port named by the command
  input wire logic [PORT_W-1:0] work_value, // working register value
  output logic [PORT_W-1:0] file_rdata, // read data
  output logic file_rvalid, // read data valid, one cycle
  input wire logic [FIRST_W-1:0] first_group_pin_in, // first pins in
  output logic [FIRST_W-1:0] first_group_pin_out, // first pins out
  output logic [FIRST_W-1:0] first_group_pin_oe, // first pins drive
  input wire logic [PORT_W-1:0] second_group_pin_in, // second pins in
  output logic [PORT_W-1:0] second_group_pin_out, // second pins out
  output logic [PORT_W-1:0] second_group_pin_oe, // second pins drive
  input wire logic [PORT_W-1:0] third_group_pin_in, // third pins in
  output logic [PORT_W-1:0] third_group_pin_out, // third pins out
  output logic [PORT_W-1:0] third_group_pin_oe // third pins drive
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [PORT_W-1:0] rdata;
    logic rvalid;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  port_sel_t rd_sel;

  port_ctl_if ctl ();

  // ************************************************************
  // command decode
  // ************************************************************
  assign ctl.wr_en = file_wr;
  assign ctl.wr_sel = addr_to_port(file_addr);
  assign ctl.wr_data = file_wdata;
  assign ctl.load_en = dir_load;
  assign ctl.load_sel = addr_to_port(dir_addr);
  assign ctl.load_data = work_value;
  assign rd_sel = addr_to_port(file_addr);

  port_data_latches u_latches (
    .clk_sys(clk_sys),
    .clk_en(clk_en),
    .ctl(ctl.latches)
  );

  port_direction_regs #(
    .HAS_THIRD_PINS(HAS_THIRD_PINS)
  ) u_direction (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .ctl(ctl.direction)
  );

  // ************************************************************
  // read path
  // ************************************************************
  // pins are sampled only at the read edge; nothing holds them before
  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    if (file_rd && rd_sel != SEL_NONE) begin
      next_state.rvalid = 1'b1;
      case (rd_sel)
        SEL_FIRST: begin
          next_state.rdata = {FIRST_UNUSED, first_group_pin_in};
        end
        SEL_SECOND: next_state.rdata = second_group_pin_in;
        SEL_THIRD: begin
          if (HAS_THIRD_PINS) begin
            next_state.rdata = third_group_pin_in;
          end else begin
            next_state.rdata = ctl.latch_third;
          end
        end
        default: next_state.rdata = RD_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= '{rdata: RD_RESET, rvalid: 1'b0};
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign file_rdata = state.rdata;
  assign file_rvalid = state.rvalid;
  assign first_group_pin_out = ctl.latch_first[FIRST_W-1:0];
  assign first_group_pin_oe = ctl.drive_first[FIRST_W-1:0];
  assign second_group_pin_out = ctl.latch_second;
  assign second_group_pin_oe = ctl.drive_second;
  assign third_group_pin_out = ctl.latch_third;
  assign third_group_pin_oe = ctl.drive_third;

endmodule : io_ports

// ==== hw/io_ports_pkg.sv ====
package io_ports_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int PORT_W = 8;
  localparam int FIRST_W = 4;
  localparam int ADDR_W = 5;

  // ************************************************************
  // file addresses of the port data registers
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_SECOND = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_THIRD = 5'h07;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PORT_W-1:0] DIR_RESET = 8'hff;
  localparam logic [PORT_W-1:0] DRIVE_RESET = ~DIR_RESET;
  localparam logic [PORT_W-1:0] RD_RESET = 8'h00;
  localparam logic [PORT_W-FIRST_W-1:0] FIRST_UNUSED = 4'h0;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_FIRST = 2'b01,
    SEL_SECOND = 2'b10,
    SEL_THIRD = 2'b11
  } port_sel_t;

  function automatic port_sel_t addr_to_port(
    input logic [ADDR_W-1:0] addr
  );
    port_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_FIRST) begin
      sel = SEL_FIRST;
    end else if (addr == ADDR_SECOND) begin
      sel = SEL_SECOND;
    end else if (addr == ADDR_THIRD) begin
      sel = SEL_THIRD;
    end
    return sel;
  endfunction : addr_to_port

endpackage : io_ports_pkg

// ==== hw/port_ctl_if.sv ====
interface port_ctl_if;
  import io_ports_pkg::*;

  logic wr_en;
  port_sel_t wr_sel;
  logic [PORT_W-1:0] wr_data;
  logic load_en;
  port_sel_t load_sel;
  logic [PORT_W-1:0] load_data;
  logic [PORT_W-1:0] latch_first;
  logic [PORT_W-1:0] latch_second;
  logic [PORT_W-1:0] latch_third;
  logic [PORT_W-1:0] drive_first;
  logic [PORT_W-1:0] drive_second;
  logic [PORT_W-1:0] drive_third;

  modport ctrl (
    output wr_en, wr_sel, wr_data, load_en, load_sel, load_data,
    input latch_first, latch_second, latch_third,
    input drive_first, drive_second, drive_third
  );
  modport latches (
    input wr_en, wr_sel, wr_data,
    output latch_first, latch_second, latch_third
  );
  modport direction (
    input load_en, load_sel, load_data,
    output drive_first, drive_second, drive_third
  );
endinterface : port_ctl_if

// ==== hw/port_data_latches.sv ====
module port_data_latches
  import io_ports_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic clk_en, // freezes state while low
  port_ctl_if.latches ctl // write side and latch outputs
);

  typedef struct packed {
    logic [PORT_W-1:0] first;
    logic [PORT_W-1:0] second;
    logic [PORT_W-1:0] third;
  } latch_state_t;

  latch_state_t state;
  latch_state_t next_state;

  // ************************************************************
  // output latches
  // ************************************************************
  // written whatever the direction, so the value waits for the driver
  always_comb begin
    next_state = state;
    if (ctl.wr_en) begin
      case (ctl.wr_sel)
        SEL_FIRST: next_state.first = ctl.wr_data;
        SEL_SECOND: next_state.second = ctl.wr_data;
        SEL_THIRD: next_state.third = ctl.wr_data;
        default: next_state = state;
      endcase
    end
  end

  // no reset on purpose: unknown at power-on, kept over later resets
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      state <= next_state;
    end
  end

  assign ctl.latch_first = state.first;
  assign ctl.latch_second = state.second;
  assign ctl.latch_third = state.third;

endmodule : port_data_latches

// ==== hw/port_direction_regs.sv ====
module port_direction_regs
  import io_ports_pkg::*;
#(
  parameter bit HAS_THIRD_PINS = 1'b1 // third port has pins
)(
  input wire logic clk_sys, // core clock
  input wire logic resetn, // any reset, active low
  input wire logic clk_en, // freezes state while low
  port_ctl_if.direction ctl // load side and driver enables
);

  // drive bits are the inverted direction bits, kept so that the
  // pin enables leave straight from a flop
  typedef struct packed {
    logic [PORT_W-1:0] first;
    logic [PORT_W-1:0] second;
    logic [PORT_W-1:0] third;
  } drive_state_t;

  drive_state_t state;
  drive_state_t next_state;

  always_comb begin
    next_state = state;
    if (ctl.load_en) begin
      case (ctl.load_sel)
        SEL_FIRST: begin
          next_state.first = {FIRST_UNUSED, ~ctl.load_data[FIRST_W-1:0]};
        end
        SEL_SECOND: next_state.second = ~ctl.load_data;
        SEL_THIRD: begin
          if (HAS_THIRD_PINS) begin
            next_state.third = ~ctl.load_data;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= {DRIVE_RESET, DRIVE_RESET, DRIVE_RESET};
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign ctl.drive_first = state.first;
  assign ctl.drive_second = state.second;
  assign ctl.drive_third = state.third;

endmodule : port_direction_regs

// ==== verif/io_ports_bench.sv ====
module io_ports_bench
  import io_ports_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic file_wr = 1'b0, file_rd = 1'b0, dir_load = 1'b0, file_rvalid;
  logic [ADDR_W-1:0] file_addr = 5'h00, dir_addr = 5'h00;
  logic [PORT_W-1:0] file_wdata = 8'h00, work_value = 8'h00, file_rdata;
  logic [FIRST_W-1:0] a_out, a_oe, a_pin, a_en = 4'h0, a_val = 4'h0;
  logic [PORT_W-1:0] b_out, b_oe, b_pin, c_out, c_oe, c_pin;
  logic [PORT_W-1:0] b_en = 8'h00, b_val = 8'h00, c_en = 8'h00;
  logic [PORT_W-1:0] s_rdata, s_c_oe;
  logic s_rvalid;
  int bad_count = 0, n_checks = 0;
  io_ports io_ports_i (.clk_sys, .resetn, .clk_en, .file_wr, .file_rd,
    .file_addr, .file_wdata, .dir_load, .dir_addr, .work_value,
    .file_rdata, .file_rvalid, .first_group_pin_in(a_pin),
    .first_group_pin_out(a_out), .first_group_pin_oe(a_oe),
    .second_group_pin_in(b_pin), .second_group_pin_out(b_out),
    .second_group_pin_oe(b_oe), .third_group_pin_in(c_pin),
    .third_group_pin_out(c_out), .third_group_pin_oe(c_oe));
  // small variant shares the bus and the pins; third port is storage
  io_ports #(.HAS_THIRD_PINS(1'b0)) io_ports_small_i (.clk_sys, .resetn,
    .clk_en, .file_wr, .file_rd, .file_addr, .file_wdata, .dir_load,
    .dir_addr, .work_value, .file_rdata(s_rdata), .file_rvalid(s_rvalid),
    .first_group_pin_in(a_pin), .first_group_pin_out(),
    .first_group_pin_oe(), .second_group_pin_in(b_pin),
    .second_group_pin_out(), .second_group_pin_oe(),
    .third_group_pin_in(c_pin), .third_group_pin_out(),
    .third_group_pin_oe(s_c_oe));
  pin_world #(.W(4)) pin_world_a (.out(a_out), .oe(a_oe), .ext_en(a_en),
    .ext_val(a_val), .pin(a_pin));
  pin_world pin_world_b (.out(b_out), .oe(b_oe), .ext_en(b_en),
    .ext_val(b_val), .pin(b_pin));
  pin_world pin_world_c (.out(c_out), .oe(c_oe), .ext_en(c_en),
    .ext_val(8'h00), .pin(c_pin));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    file_wr = 1'b1;
    file_addr = a;
    file_wdata = d;
    @(negedge clk_sys);
    file_wr = 1'b0;
  endtask : wr
  task automatic dl(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    dir_load = 1'b1;
    dir_addr = a;
    work_value = v;
    @(negedge clk_sys);
    dir_load = 1'b0;
  endtask : dl
  task automatic rd(input logic [4:0] a, input logic v, input logic [7:0] e);
    @(negedge clk_sys);
    file_rd = 1'b1;
    file_addr = a;
    @(negedge clk_sys);
    file_rd = 1'b0;
    chk({7'h0, file_rvalid}, {7'h0, v});
    if (v) chk(file_rdata, e);
  endtask : rd
  task automatic t_read();
    a_en = 4'hf;
    a_val = 4'hc;
    b_en = 8'hff;
    b_val = 8'ha5;
    rd(ADDR_FIRST, 1'b1, 8'h0c);
    rd(ADDR_SECOND, 1'b1, 8'ha5);
    b_val = 8'h5a;
    rd(ADDR_SECOND, 1'b1, 8'h5a);
    rd(5'h08, 1'b0, 8'h00);
    $display("t_read done");
  endtask : t_read
  task automatic t_drive();
    b_en = 8'h00;
    wr(ADDR_SECOND, 8'h3c);
    chk(b_out, 8'h3c);
    chk(b_pin, 8'hff);
    dl(ADDR_SECOND, 8'h0f);
    chk(b_oe, 8'hf0);
    rd(ADDR_SECOND, 1'b1, 8'h3f);
    b_en = 8'h30;
    b_val = 8'h00;
    rd(ADDR_SECOND, 1'b1, 8'h0f);
    $display("t_drive done");
  endtask : t_drive
  task automatic t_hold();
    clk_en = 1'b0;
    wr(ADDR_SECOND, 8'hff);
    clk_en = 1'b1;
    wr(ADDR_THIRD, 8'h5a);
    wr(ADDR_FIRST, 8'h09);
    chk(b_out, 8'h3c);
    chk({4'h0, a_out}, 8'h09);
    dl(ADDR_FIRST, 8'hfa);
    chk({4'h0, a_oe}, 8'h05);
    dl(ADDR_THIRD, 8'h00);
    rd(ADDR_THIRD, 1'b1, 8'h5a);
    c_en = 8'hff;
    rd(ADDR_THIRD, 1'b1, 8'h00);
    chk(s_rdata, 8'h5a);
    chk({7'h0, s_rvalid}, 8'h01);
    chk(s_c_oe, 8'h00);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_reset(input logic [7:0] b_exp);
    chk({a_oe, 4'h0} | b_oe | c_oe, 8'h00);
    chk(b_out, b_exp);
    $display("t_reset done");
  endtask : t_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100us;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset(8'hxx);
    t_read();
    t_drive();
    t_hold();
    resetn = 1'b0;
    @(negedge clk_sys);
    resetn = 1'b1;
    t_reset(8'h3c);
    finish_test();
  end
endmodule : io_ports_bench

// ==== verif/io_ports_sva.sv ====
module io_ports_sva
  import io_ports_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic clk_en, // run
  input wire logic file_wr, // write
  input wire logic file_rd, // read
  input wire logic [ADDR_W-1:0] file_addr, // address
  input wire logic [PORT_W-1:0] file_wdata, // data
  input wire logic dir_load, // load
  input wire logic [ADDR_W-1:0] dir_addr, // port
  input wire logic [PORT_W-1:0] work_value, // value
  input wire logic [PORT_W-1:0] file_rdata, // data
  input wire logic file_rvalid, // valid
  input wire logic [FIRST_W-1:0] first_group_pin_in, // pins
  input wire logic [PORT_W-1:0] second_group_pin_in, // pins
  input wire logic [PORT_W-1:0] second_group_pin_out, // latch
  input wire logic [PORT_W-1:0] second_group_pin_oe // drive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd_any, rd_a, rd_b, wr_b, ld_b;
  logic seen = 1'b0; // latch unknown until first write
  // mapped read request, before the enable qualifies it
  assign rd_any = file_rd && file_addr >= ADDR_FIRST
    && file_addr <= ADDR_THIRD;
  assign rd_a = clk_en && file_rd && file_addr == ADDR_FIRST;
  assign rd_b = clk_en && file_rd && file_addr == ADDR_SECOND;
  assign wr_b = clk_en && file_wr && file_addr == ADDR_SECOND;
  assign ld_b = clk_en && dir_load && dir_addr == ADDR_SECOND;
  always_ff @(posedge clk_sys) begin
    if (wr_b) begin
      seen <= 1'b1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_rv; clk_en && rd_any |=> file_rvalid; endproperty
  // a frozen cycle keeps the old pulse, so only enabled edges count
  property p_norv; clk_en && !rd_any |=> !file_rvalid; endproperty
  property p_frz;
    !clk_en |=> $stable(file_rvalid) && $stable(file_rdata)
      && $stable(second_group_pin_out) && $stable(second_group_pin_oe);
  endproperty
  property p_rdb;
    rd_b |=> file_rdata == $past(second_group_pin_in);
  endproperty
  property p_rda;
    rd_a |=> file_rdata == {4'h0, $past(first_group_pin_in)};
  endproperty
  property p_wrb;
    wr_b |=> second_group_pin_out == $past(file_wdata);
  endproperty
  property p_holdb;
    $past(seen) && !wr_b |=> $stable(second_group_pin_out);
  endproperty
  property p_ldb;
    ld_b |=> second_group_pin_oe == ~$past(work_value);
  endproperty
  property p_rst;
    disable iff (1'b0) !resetn |=> second_group_pin_oe == 8'h00;
  endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  a_norv: assert property (p_norv) else $error("stray rvalid");
  a_rdb: assert property (p_rdb) else $error("bad read");
  a_rda: assert property (p_rda) else $error("bad read");
  a_wrb: assert property (p_wrb) else $error("bad write");
  a_holdb: assert property (p_holdb) else $error("moved");
  a_ldb: assert property (p_ldb) else $error("bad drive");
  a_rst: assert property (p_rst) else $error("drives");
  a_frz: assert property (p_frz) else $error("not frozen");
  c_wr: cover property (wr_b);
  c_ld: cover property (ld_b);
  c_rd: cover property (rd_b ##1 file_rvalid);
endmodule : io_ports_sva

bind io_ports io_ports_sva io_ports_sva_i (.clk_sys, .resetn, .clk_en,
  .file_wr, .file_rd, .file_addr, .file_wdata, .dir_load, .dir_addr,
  .work_value, .file_rdata, .file_rvalid, .first_group_pin_in,
  .second_group_pin_in, .second_group_pin_out, .second_group_pin_oe);

// ==== verif/pin_world.sv ====
module pin_world #(
  parameter int W = 8 // pins
)(
  input wire logic [W-1:0] out, // latch
  input wire logic [W-1:0] oe, // drive
  input wire logic [W-1:0] ext_en, // outside drives
  input wire logic [W-1:0] ext_val, // outside level
  output logic [W-1:0] pin // level
);
  timeunit 1ns;
  timeprecision 1ns;
  // outside wins a fight; floating pins sit on board pull-ups
  // outside levels change only when the bench says so
  assign pin = (ext_en & ext_val) | (~ext_en & (out | ~oe));
endmodule : pin_world
